/* core/fmc_cfg.svh */
// Address map, field positions, reset values and timing for the flash mode control block
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define FMC_ADDR_MODE_CTRL    16'hff80
`define FMC_ADDR_LARGE_SEL    16'hff82
`define FMC_ADDR_SMALL_SEL    16'hff83
`define FMC_ADDR_WAIT_OVL     16'hffc2
`define FMC_CTRL_WIN_LO       16'hff80
`define FMC_CTRL_WIN_HI       16'hff83

// ----------------------------------------------------------------
// Flash array window and RAM overlay ranges
// ----------------------------------------------------------------
`define FMC_FLASH_LO          16'h0000
`define FMC_FLASH_HI          16'h7fff
`define FMC_OVL_B_LO          16'h0080
`define FMC_OVL_B_HI          16'h00ff
`define FMC_OVL_A_LO          16'h0080
`define FMC_OVL_A_HI          16'h017f
`define FMC_OVL_AB_LO         16'h0000
`define FMC_OVL_AB_HI         16'h007f
`define FMC_RAM_OVL_OFS       16'hfc00

// ----------------------------------------------------------------
// Reset and fixed read values
// ----------------------------------------------------------------
`define FMC_MODE_CTRL_RST     8'h00
`define FMC_MODE_CTRL_VPP_RST 8'h80
`define FMC_LARGE_SEL_RST     8'hf0
`define FMC_SMALL_SEL_RST     8'h00
`define FMC_WAIT_OVL_RST      8'h08
`define FMC_LOCKED_READ       8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FMC_VPP_BIT           7
`define FMC_EV_BIT            3
`define FMC_PV_BIT            2
`define FMC_E_BIT             1
`define FMC_P_BIT             0
`define FMC_OVL_A_BIT         7
`define FMC_OVL_B_BIT         6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FMC_CLK_HZ            40000000
`define FMC_BOOT_MAX_BPS      9600
`define FMC_BOOT_MIN_BIT_CYC  ((`FMC_CLK_HZ + `FMC_BOOT_MAX_BPS - 1) / `FMC_BOOT_MAX_BPS)
`define FMC_BOOT_SYNC_BITS    9

`endif

/* core/fmc_pkg.sv */
// Types shared by the flash mode control block
package fmc_pkg;

	// ----------------------------------------------------------------
	// Bus cycle states, Gray along idle -> T1 -> T2
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FMC_BUS_IDLE = 2'b00,
		FMC_BUS_T1   = 2'b01,
		FMC_BUS_T2   = 2'b11
	} fmc_bus_state_e;

	// ----------------------------------------------------------------
	// Where a CPU access is routed
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FMC_RT_NONE  = 3'b000,
		FMC_RT_FLASH = 3'b001,
		FMC_RT_RAM   = 3'b011,
		FMC_RT_REG   = 3'b010,
		FMC_RT_EXT   = 3'b110
	} fmc_route_e;

	// ----------------------------------------------------------------
	// Flash operating mode presented to the array
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FMC_OP_READ   = 3'b000,
		FMC_OP_PROG   = 3'b001,
		FMC_OP_PVER   = 3'b011,
		FMC_OP_PWVER  = 3'b010,
		FMC_OP_ERASE  = 3'b110,
		FMC_OP_EVER   = 3'b111
	} fmc_op_e;

	// ----------------------------------------------------------------
	// Bit-rate measurement states, Gray along the path
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FMC_BR_IDLE = 2'b00,
		FMC_BR_WAIT = 2'b01,
		FMC_BR_MEAS = 2'b11,
		FMC_BR_DONE = 2'b10
	} fmc_baud_state_e;

endpackage

/* core/fmc_baud_if.sv */
// Carrier between the control top and the boot bit-rate measurement unit
`timescale 1ns/1ps
`default_nettype none
interface fmc_baud_if #(parameter int CNT_W = 20);
	logic             enable;   // Boot mode active
	logic             rx;       // Host serial line
	logic             locked;   // Bit rate measured
	logic [CNT_W-1:0] bit_cyc;  // Clocks per bit

	modport meas (input enable, input rx, output locked, output bit_cyc);
	modport ctrl (output enable, output rx, input locked, input bit_cyc);
endinterface
`default_nettype wire

/* core/fmc_baud_meas.sv */
// Boot-mode bit-rate measurement from the host's all-zero sync byte
`timescale 1ns/1ps
`default_nettype none
`include "fmc_cfg.svh"
module fmc_baud_meas
	import fmc_pkg::*;
#(
	parameter int CNT_W       = 20,
	parameter int MIN_BIT_CYC = `FMC_BOOT_MIN_BIT_CYC
) (
	input  wire logic  clk_in,
	input  wire logic  arst_n_in,
	fmc_baud_if.meas   br
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fmc_baud_state_e  state_q;   // Measurement phase
	logic [CNT_W-1:0] cnt_q;     // Low-time counter
	logic             rx_q;      // Previous line level
	logic [CNT_W-1:0] bit_cyc_q; // Result in clocks per bit

	// Shortest legal sync low time: nine bits at the fastest host rate
	localparam logic [CNT_W-1:0] MIN_LOW =
		CNT_W'(MIN_BIT_CYC * `FMC_BOOT_SYNC_BITS);

	// ----------------------------------------------------------------
	// Line history for edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_q <= 1'b1;
		end else begin
			rx_q <= br.rx;
		end
	end

	// ----------------------------------------------------------------
	// Sync byte measurement: start plus eight zero bits stay low
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q   <= FMC_BR_IDLE;
			cnt_q     <= '0;
			bit_cyc_q <= '0;
		end else if (!br.enable) begin
			// Leaving boot mode forgets the rate
			state_q   <= FMC_BR_IDLE;
			cnt_q     <= '0;
			bit_cyc_q <= '0;
		end else begin
			case (state_q)
				FMC_BR_IDLE: begin
					// Wait for an idle-high line so a stuck low is not timed
					if (br.rx) begin
						state_q <= FMC_BR_WAIT;
					end
				end
				FMC_BR_WAIT: begin
					if (rx_q && !br.rx) begin
						state_q <= FMC_BR_MEAS;
						cnt_q   <= CNT_W'(1);
					end
				end
				FMC_BR_MEAS: begin
					if (br.rx) begin
						// Too short means faster than the top rate: retry
						if (cnt_q >= MIN_LOW) begin // R6
							bit_cyc_q <= CNT_W'(cnt_q / CNT_W'(`FMC_BOOT_SYNC_BITS)); // R6
							state_q   <= FMC_BR_DONE;
						end else begin
							state_q <= FMC_BR_WAIT;
						end
					end else if (cnt_q != '1) begin
						// Saturate rather than wrap on a very slow host
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				FMC_BR_DONE: begin
					state_q <= FMC_BR_DONE;
				end
				default: begin
					state_q <= FMC_BR_IDLE;
				end
			endcase
		end
	end

	assign br.locked  = (state_q == FMC_BR_DONE);
	assign br.bit_cyc = bit_cyc_q;
endmodule
`default_nettype wire

/* core/fmc_ctrl.sv */
// Flash mode control: address decode, mode-pin routing and gated control registers
`timescale 1ns/1ps
`default_nettype none
`include "fmc_cfg.svh"
// Summary of operation
// R1: Flash occupies addresses 0000 through 7FFF
// R2: Sixteen-bit path, byte and word in two states
// R3: Mode pins pick external or on-chip region
// R4: Five modes: program, verifies, erase, prewrite-verify
// R5: Select bits choose large and small blocks
// R6: Boot mode measures and matches host bit rate
// R7: Serial pins carry boot data only in boot
// R8: RAM can overlay part of flash range
// R9: Control registers accessible only with 12 V
// R10: No 12 V: mode 2 external, mode 3 ones
// R11: Mode 1 registers unwritable, read all ones
// R12: Modes 2/3 reset values 00, F0, 00
// R13: Mode control clears on reset, standby, no supply
// R14: Supply present at reset reads 80
// R15: Top bit reports programming supply present
// R16: Bits six to four read zero
// R17: Bit 3 selects erase-verify mode
// R18: Bit 2 selects program-verify mode
// R19: Bit 1 selects erase mode
// R20: Bit 0 selects program mode
// R21: Software sets at most one mode bit
// R22: Software arms watchdog before program or erase
// R23: Only selected blocks program or erase
// R24: Single overlay bit protects; verify still allowed
// R25: Mode bits ignore writes without 12 V
module fmc_ctrl
	import fmc_pkg::*;
#(
	parameter int BOOT_MIN_BIT_CYC = `FMC_BOOT_MIN_BIT_CYC,
	parameter int BAUD_CNT_W       = 20
) (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	// CPU internal bus
	input  wire logic        bus_req_in,
	input  wire logic        bus_wr_in,
	input  wire logic        bus_word_in,
	input  wire logic [15:0] bus_addr_in,
	input  wire logic [15:0] bus_wdata_in,
	output logic      [15:0] bus_rdata_out,
	output logic             bus_ack_out,
	output logic             bus_ext_out,
	// Pins and system state
	input  wire logic        mode_pin_high_in,
	input  wire logic        mode_pin_low_in,
	input  wire logic        high_voltage_pin_in,
	input  wire logic        standby_in,
	input  wire logic        hw_standby_in,
	input  wire logic        irq_in,
	input  wire logic        boot_mode_in,
	// Flash array and overlay RAM
	output logic      [15:0] mem_addr_out,
	output logic      [15:0] mem_wdata_out,
	output logic             flash_sel_out,
	output logic             ram_sel_out,
	output logic             mem_wr_out,
	input  wire logic [15:0] flash_rdata_in,
	input  wire logic [15:0] ram_rdata_in,
	output fmc_op_e          flash_op_out,
	output logic      [3:0]  large_blk_en_out,
	output logic      [7:0]  small_blk_en_out,
	output logic      [7:0]  wait_and_overlay_out,
	// Boot serial pins and the serial channel behind them
	input  wire logic        boot_serial_in_in,
	output logic             boot_serial_out_out,
	input  wire logic        sci_txd_in,
	output logic             sci_rxd_out,
	output logic             baud_locked_out,
	output logic [BAUD_CNT_W-1:0] baud_bit_cyc_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	fmc_bus_state_e state_q;       // Bus cycle phase
	fmc_route_e     route_q;       // Target of the access in flight
	logic [15:0]    addr_q;        // CPU byte address held
	logic [15:0]    wdata_q;       // Write data held
	logic           wr_q;          // Access is a write
	logic           word_q;        // Access is a word
	logic [15:0]    rdata_q;       // Read data to CPU
	logic [3:0]     mode_bits_q;   // Erase-verify, program-verify, erase, program
	logic [3:0]     large_sel_q;   // Large block selects
	logic [7:0]     small_sel_q;   // Small block selects
	logic [7:0]     wait_ovl_q;    // Wait and overlay control
	logic           ovl_live_q;    // Double-bit overlay armed by interrupt
	logic           prog_seen_q;   // Program done since last erase
	fmc_op_e        op_q;          // Registered array mode
	fmc_route_e     route_d;       // Route of a new request
	logic           on_chip;       // Modes 2 and 3
	logic           vpp;           // Programming supply present
	logic           ctrl_open;     // Control registers reachable
	logic           emu_protect;   // Exactly one overlay bit set
	logic           wr_cycle;      // Register write lands this cycle
	logic [8:0]     wr_mc, wr_ls, wr_ss, wr_wo; // {hit, data} for each register

	fmc_baud_if #(.CNT_W(BAUD_CNT_W)) br_if ();

	assign on_chip     = mode_pin_high_in; // R3
	assign vpp         = high_voltage_pin_in;
	assign ctrl_open   = on_chip && vpp; // R9
	assign emu_protect = wait_ovl_q[`FMC_OVL_A_BIT] ^ wait_ovl_q[`FMC_OVL_B_BIT]; // R24

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Overlay window hit for an address under the current overlay bits
	function automatic logic ovl_hit(input logic [15:0] a);
		logic [1:0] sel;
		sel = {wait_ovl_q[`FMC_OVL_A_BIT], wait_ovl_q[`FMC_OVL_B_BIT]};
		case (sel)
			2'b01:   ovl_hit = (a >= `FMC_OVL_B_LO) && (a <= `FMC_OVL_B_HI);
			2'b10:   ovl_hit = (a >= `FMC_OVL_A_LO) && (a <= `FMC_OVL_A_HI);
			2'b11:   ovl_hit = ovl_live_q && (a <= `FMC_OVL_AB_HI);
			default: ovl_hit = 1'b0;
		endcase
	endfunction

	// Read value of one register byte; control bytes depend on the gate
	function automatic logic [7:0] reg_rd(input logic [15:0] a);
		reg_rd = 8'h00;
		if (a == `FMC_ADDR_WAIT_OVL) begin
			reg_rd = wait_ovl_q;
		end else if (!ctrl_open) begin
			reg_rd = `FMC_LOCKED_READ; // R10 R11
		end else if (a == `FMC_ADDR_MODE_CTRL) begin
			// Supply flag live on top, reserved bits zero
			reg_rd = {vpp, 3'b000, mode_bits_q}; // R15 R16 R14
		end else if (a == `FMC_ADDR_LARGE_SEL) begin
			reg_rd = {4'hf, large_sel_q};
		end else if (a == `FMC_ADDR_SMALL_SEL) begin
			reg_rd = small_sel_q;
		end
	endfunction

	// Byte lane aimed at register address t by the held access
	function automatic logic [8:0] lane(input logic [15:0] t);
		lane = 9'h000;
		if (word_q && ({addr_q[15:1], 1'b0} == t)) begin
			lane = {1'b1, wdata_q[15:8]};
		end else if (word_q && ({addr_q[15:1], 1'b1} == t)) begin
			lane = {1'b1, wdata_q[7:0]};
		end else if (!word_q && (addr_q == t)) begin
			lane = {1'b1, wdata_q[7:0]};
		end
	endfunction

	// ----------------------------------------------------------------
	// Route decode for a new request
	// ----------------------------------------------------------------
	always_comb begin
		route_d = FMC_RT_NONE;
		if (bus_addr_in <= `FMC_FLASH_HI) begin // R1
			if (!on_chip) begin
				route_d = FMC_RT_EXT; // R3
			end else if (ovl_hit(bus_addr_in)) begin
				route_d = FMC_RT_RAM; // R8
			end else begin
				route_d = FMC_RT_FLASH;
			end
		end else if (bus_addr_in == `FMC_ADDR_WAIT_OVL) begin
			route_d = FMC_RT_REG;
		end else if ((bus_addr_in >= `FMC_CTRL_WIN_LO) && (bus_addr_in <= `FMC_CTRL_WIN_HI)) begin
			// Mode 2 without supply hands the window to the outside
			if (on_chip && !mode_pin_low_in && !vpp) begin
				route_d = FMC_RT_EXT; // R10
			end else begin
				route_d = FMC_RT_REG;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus cycle: accept, T1 with memory selected, T2 with answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= FMC_BUS_IDLE;
			route_q <= FMC_RT_NONE;
			addr_q  <= 16'h0000;
			wdata_q <= 16'h0000;
			wr_q    <= 1'b0;
			word_q  <= 1'b0;
		end else begin
			case (state_q)
				FMC_BUS_IDLE: begin
					if (bus_req_in) begin
						state_q <= FMC_BUS_T1;
						route_q <= route_d;
						// Word accesses always sit on an even address
						addr_q  <= bus_word_in ? {bus_addr_in[15:1], 1'b0} : bus_addr_in;
						wdata_q <= bus_wdata_in;
						wr_q    <= bus_wr_in;
						word_q  <= bus_word_in;
					end
				end
				FMC_BUS_T1: begin
					state_q <= FMC_BUS_T2; // R2
				end
				FMC_BUS_T2: begin
					state_q <= FMC_BUS_IDLE;
				end
				default: begin
					state_q <= FMC_BUS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data capture at the end of T1
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q <= 16'h0000;
		end else if (state_q == FMC_BUS_T1) begin
			case (route_q)
				FMC_RT_FLASH: rdata_q <= flash_rdata_in; // R2
				FMC_RT_RAM:   rdata_q <= ram_rdata_in;
				FMC_RT_REG: begin
					if (word_q) begin
						rdata_q <= {reg_rd(addr_q), reg_rd({addr_q[15:1], 1'b1})};
					end else begin
						rdata_q <= {8'h00, reg_rd(addr_q)};
					end
				end
				default:      rdata_q <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register write strobes, landing at the end of T1
	// ----------------------------------------------------------------
	assign wr_cycle = (state_q == FMC_BUS_T1) && wr_q && (route_q == FMC_RT_REG);
	assign wr_mc    = lane(`FMC_ADDR_MODE_CTRL);
	assign wr_ls    = lane(`FMC_ADDR_LARGE_SEL);
	assign wr_ss    = lane(`FMC_ADDR_SMALL_SEL);
	assign wr_wo    = lane(`FMC_ADDR_WAIT_OVL);

	// ----------------------------------------------------------------
	// Mode control bits; supply loss and standby win over a write
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_bits_q <= 4'(`FMC_MODE_CTRL_RST); // R12 R13
		end else if (standby_in || hw_standby_in || !vpp) begin
			mode_bits_q <= 4'h0; // R13 R25
		end else if (wr_cycle && wr_mc[8] && ctrl_open) begin
			// Two bits at once is a software fault; hardware stores as written
			mode_bits_q <= wr_mc[3:0]; // R17 R18 R19 R20 R21
		end
	end

	// ----------------------------------------------------------------
	// Block selects, cleared like the mode bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			large_sel_q <= 4'(`FMC_LARGE_SEL_RST); // R12
			small_sel_q <= `FMC_SMALL_SEL_RST; // R12
		end else if (standby_in || hw_standby_in || !vpp) begin
			large_sel_q <= 4'h0;
			small_sel_q <= `FMC_SMALL_SEL_RST;
		end else if (wr_cycle && ctrl_open) begin // R9 R11
			if (wr_ls[8]) begin
				large_sel_q <= wr_ls[3:0]; // R5
			end
			if (wr_ss[8]) begin
				small_sel_q <= wr_ss[7:0]; // R5
			end
		end
	end

	// ----------------------------------------------------------------
	// Wait and overlay control; software standby keeps it
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_ovl_q <= `FMC_WAIT_OVL_RST;
		end else if (hw_standby_in) begin
			wait_ovl_q <= `FMC_WAIT_OVL_RST;
		end else if (wr_cycle && wr_wo[8]) begin
			wait_ovl_q <= wr_wo[7:0]; // R8
		end
	end

	// ----------------------------------------------------------------
	// Double-bit overlay waits for an interrupt under supply
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ovl_live_q <= 1'b0;
		end else if (!(wait_ovl_q[`FMC_OVL_A_BIT] && wait_ovl_q[`FMC_OVL_B_BIT])) begin
			ovl_live_q <= 1'b0;
		end else if (irq_in && vpp) begin
			ovl_live_q <= 1'b1; // R8
		end
	end

	// ----------------------------------------------------------------
	// Array mode; protect refuses program and erase, not verifies
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			op_q        <= FMC_OP_READ;
			prog_seen_q <= 1'b0;
		end else begin
			op_q <= FMC_OP_READ;
			if (mode_bits_q[`FMC_P_BIT] && !emu_protect) begin
				op_q        <= FMC_OP_PROG; // R20 R24 R4
				prog_seen_q <= 1'b1;
			end else if (mode_bits_q[`FMC_E_BIT] && !emu_protect) begin
				op_q        <= FMC_OP_ERASE; // R19 R24
				prog_seen_q <= 1'b0;
			end else if (mode_bits_q[`FMC_PV_BIT]) begin
				// Verify before any program since erase is prewrite-verify
				op_q <= prog_seen_q ? FMC_OP_PVER : FMC_OP_PWVER; // R18 R4
			end else if (mode_bits_q[`FMC_EV_BIT]) begin
				op_q <= FMC_OP_EVER; // R17
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_ack_out   = (state_q == FMC_BUS_T2);
	assign bus_rdata_out = rdata_q;
	assign bus_ext_out   = (state_q != FMC_BUS_IDLE) && (route_q == FMC_RT_EXT);
	// RAM overlay is reached at the same offset above the fixed base
	assign mem_addr_out  = (route_q == FMC_RT_RAM) ? (addr_q + `FMC_RAM_OVL_OFS) : addr_q; // R8
	assign mem_wdata_out = wdata_q;
	assign flash_sel_out = (state_q == FMC_BUS_T1) && (route_q == FMC_RT_FLASH);
	assign ram_sel_out   = (state_q == FMC_BUS_T1) && (route_q == FMC_RT_RAM);
	assign mem_wr_out    = (state_q == FMC_BUS_T1) && wr_q
		&& ((route_q == FMC_RT_FLASH) || (route_q == FMC_RT_RAM));
	assign flash_op_out  = op_q;
	// Only a block both selected and under program or erase is enabled
	assign large_blk_en_out = ((op_q == FMC_OP_PROG) || (op_q == FMC_OP_ERASE))
		? large_sel_q : 4'h0; // R23
	assign small_blk_en_out = ((op_q == FMC_OP_PROG) || (op_q == FMC_OP_ERASE))
		? small_sel_q : 8'h00; // R23
	assign wait_and_overlay_out = wait_ovl_q;

	// ----------------------------------------------------------------
	// Boot serial pins and bit-rate measurement
	// ----------------------------------------------------------------
	assign boot_serial_out_out = boot_mode_in ? sci_txd_in : 1'b1; // R7
	assign sci_rxd_out         = boot_mode_in ? boot_serial_in_in : 1'b1; // R7
	assign br_if.enable        = boot_mode_in;
	assign br_if.rx            = boot_serial_in_in;
	assign baud_locked_out     = br_if.locked;
	assign baud_bit_cyc_out    = br_if.bit_cyc;

	fmc_baud_meas #(
		.CNT_W       (BAUD_CNT_W),
		.MIN_BIT_CYC (BOOT_MIN_BIT_CYC)
	) u_baud (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.br        (br_if.meas)
	);
endmodule
`default_nettype wire

/* dv/fmc_mem_model.sv */
// Flash array and overlay RAM stand-in on the block's memory port
`timescale 1ns/1ps
`default_nettype none
module fmc_mem_model (
	input  wire logic        clk_in,
	input  wire logic        flash_sel_in,
	input  wire logic        ram_sel_in,
	input  wire logic [15:0] addr_in,
	output logic      [15:0] flash_rd_out,
	output logic      [15:0] ram_rd_out
);
	// Unselected data churns every cycle, so stale data never passes as an answer
	logic [15:0] churn_q = 16'h1234;
	always @(posedge clk_in) churn_q <= churn_q + 16'h3d1b;
	assign flash_rd_out = flash_sel_in ? addr_in ^ 16'ha5a5 : churn_q;
	assign ram_rd_out   = ram_sel_in ? addr_in ^ 16'h5a5a : ~churn_q;
endmodule
`default_nettype wire

/* dv/fmc_ctrl_checker.sv */
// Port-level checks for the flash mode control block
`timescale 1ns/1ps
`default_nettype none
module fmc_ctrl_checker
	import fmc_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        arst_n_in,
	input wire logic        bus_ack_out,
	input wire logic        flash_sel_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic        mode_pin_high_in,
	input wire logic        high_voltage_pin_in,
	input wire logic        standby_in,
	input wire fmc_op_e     flash_op_out,
	input wire logic [3:0]  large_blk_en_out,
	input wire logic [7:0]  small_blk_en_out,
	input wire logic [7:0]  wait_and_overlay_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire wr_op = flash_op_out inside {FMC_OP_PROG, FMC_OP_ERASE}; // Program or erase reaching array
	wire ovl_one = wait_and_overlay_out[7] ^ wait_and_overlay_out[6]; // Exactly one overlay bit
	property p_ack; $rose(flash_sel_out) |=> bus_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("no answer after T1");
	property p_pulse; bus_ack_out |=> !bus_ack_out; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_range; flash_sel_out |-> !mem_addr_out[15]; endproperty
	a_range: assert property (p_range) else $error("flash outside window");
	property p_ext; !mode_pin_high_in [*2] |-> !flash_sel_out; endproperty
	a_ext: assert property (p_ext) else $error("flash used in mode 1");
	property p_vpp; !high_voltage_pin_in [*4] |-> flash_op_out == FMC_OP_READ; endproperty
	a_vpp: assert property (p_vpp) else $error("mode without supply");
	property p_stby; standby_in [*3] |-> flash_op_out == FMC_OP_READ; endproperty
	a_stby: assert property (p_stby) else $error("mode kept in standby");
	property p_blk; !wr_op [*2] |-> {large_blk_en_out, small_blk_en_out} == 12'h000; endproperty
	a_blk: assert property (p_blk) else $error("block enabled idle");
	property p_ovl; ovl_one [*2] |-> !wr_op; endproperty
	a_ovl: assert property (p_ovl) else $error("write under overlay");
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the flash mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import fmc_pkg::*;
	logic clk_in = 1'b0, arst_n_in = 1'b0, bus_req_in = 1'b0, bus_wr_in = 1'b0;
	logic bus_word_in = 1'b0, standby_in = 1'b0, hw_standby_in = 1'b0, irq_in = 1'b0;
	logic mode_pin_high_in = 1'b1, mode_pin_low_in = 1'b0, high_voltage_pin_in = 1'b1;
	logic boot_mode_in = 1'b0, boot_serial_in_in = 1'b1, sci_txd_in = 1'b1;
	logic [15:0] bus_addr_in = 16'h0, bus_wdata_in = 16'h0, a;
	logic [15:0] bus_rdata_out, mem_addr_out, mem_wdata_out, flash_rdata_in, ram_rdata_in;
	logic bus_ack_out, bus_ext_out, flash_sel_out, ram_sel_out, mem_wr_out;
	logic boot_serial_out_out, sci_rxd_out, baud_locked_out;
	logic [3:0] large_blk_en_out;
	logic [7:0] small_blk_en_out, wait_and_overlay_out, r, s;
	logic [19:0] baud_bit_cyc_out;
	fmc_op_e flash_op_out;
	int err_count = 0, cmp_count = 0;
	logic [17:0] exp_q[$], e_q;  // Bit 16 marks a compared read, bit 17 an external route
	logic [3:0] mb[5] = '{4'h4, 4'h1, 4'h4, 4'h2, 4'h8};
	fmc_op_e ops[5] = '{FMC_OP_PWVER, FMC_OP_PROG, FMC_OP_PVER, FMC_OP_ERASE, FMC_OP_EVER};
	fmc_ctrl #(.BOOT_MIN_BIT_CYC(4)) DUT (.*);
	fmc_mem_model MEM (.clk_in, .flash_sel_in(flash_sel_out), .ram_sel_in(ram_sel_out),
		.addr_in(mem_addr_out), .flash_rd_out(flash_rdata_in), .ram_rd_out(ram_rdata_in));
	initial forever #12.5 clk_in = ~clk_in;
	// One bus cycle: request held until the answer edge, expectation noted
	task automatic acc(input logic w, wd, input logic [15:0] ad, d, input logic [17:0] e);
		@(posedge clk_in);
		bus_req_in <= 1'b1;
		bus_wr_in <= w;
		bus_word_in <= wd;
		bus_addr_in <= ad;
		bus_wdata_in <= d;
		exp_q.push_back(e);
		for (int i = 0; i < 8 && bus_ack_out !== 1'b1; i++) @(posedge clk_in);
		bus_req_in <= 1'b0;
	endtask
	task automatic rd(input logic wd, input logic [15:0] ad, v);
		acc(1'b0, wd, ad, 16'h0, {2'b01, v});
	endtask
	task automatic wr(input logic [15:0] ad, d);
		acc(1'b1, 1'b0, ad, d, 18'h0);
	endtask
	// Oldest note is compared whenever an answer appears
	always @(posedge clk_in) if (bus_ack_out === 1'b1 && exp_q.size() > 0) begin
		e_q = exp_q.pop_front();
		if (e_q[16]) `CHK(bus_rdata_out, e_q[15:0])
		`CHK(bus_ext_out, e_q[17])
	end
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Whole run is under two hundred cycles; this leaves wide margin
	initial begin
		#75000;
		err_count++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'h73db743a));
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rd(0, 16'hff80, 16'h0080);
		rd(0, 16'hff82, 16'h00f0);
		rd(0, 16'hff83, 16'h0000);
		rd(0, 16'hffc2, 16'h0008);
		// One mode bit at a time, random junk in the read-only upper bits
		foreach (mb[i]) begin
			r = $urandom;
			wr(16'hff80, {8'h00, r[7:4], mb[i]});
			rd(0, 16'hff80, {8'h00, 4'h8, mb[i]});
			`CHK(flash_op_out, ops[i])
		end
		r = $urandom;
		s = $urandom;
		acc(1'b1, 1'b1, 16'hff82, {r, s}, 18'h0);
		rd(1, 16'hff82, {4'hf, r[3:0], s});
		wr(16'hff80, 16'h0001);
		a = 16'($urandom) & 16'h7ffe;
		rd(1, a, a ^ 16'ha5a5);
		`CHK({large_blk_en_out, small_blk_en_out}, {r[3:0], s})
		standby_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		standby_in <= 1'b0;
		rd(0, 16'hff80, 16'h0080);
		rd(1, 16'hff82, 16'hf000);
		wr(16'hffc2, 16'h0048);
		rd(1, 16'h0080, 16'hfc80 ^ 16'h5a5a);
		wr(16'hff80, 16'h0001);
		repeat (2) @(posedge clk_in);
		`CHK(flash_op_out, FMC_OP_READ)
		wr(16'hffc2, 16'h0008);
		high_voltage_pin_in <= 1'b0;
		mode_pin_low_in <= 1'b1;
		wr(16'hff83, 16'h00aa);
		rd(0, 16'hff83, 16'h00ff);
		high_voltage_pin_in <= 1'b1;
		mode_pin_high_in <= 1'b0;
		wr(16'hff82, 16'h0003);
		rd(0, 16'hff82, 16'h00ff);
		acc(1'b0, 1'b1, 16'h0100, 16'h0, 18'h20000);
		boot_mode_in <= 1'b1;
		sci_txd_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		`CHK(boot_serial_out_out, 1'b0)
		boot_serial_in_in <= 1'b0;
		repeat (45) @(posedge clk_in);
		`CHK(sci_rxd_out, 1'b0)
		boot_serial_in_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		`CHK(baud_locked_out, 1'b1)
		`CHK(baud_bit_cyc_out, 20'h5)
		wrap_up;
	end
endmodule
bind fmc_ctrl fmc_ctrl_checker CHKR (.clk_in, .arst_n_in, .bus_ack_out, .flash_sel_out,
	.mem_addr_out, .mode_pin_high_in, .high_voltage_pin_in, .standby_in, .flash_op_out,
	.large_blk_en_out, .small_blk_en_out, .wait_and_overlay_out);
`default_nettype wire
